//--- dps_defines.vh
/*
  constants for the dancer speed regulator: register offsets, field
  positions, reset values, mode codes and timing.
  assumes inclusion by bare name from the design file.
*/
`ifndef DPS_DEFINES_VH
`define DPS_DEFINES_VH
// register byte offsets
`define DPS_A_MODE    6'h00
`define DPS_A_SETPT   6'h04
`define DPS_A_BIAS    6'h08
`define DPS_A_GAIN    6'h0c
`define DPS_A_PIDK    6'h10
`define DPS_A_RAMP    6'h14
`define DPS_A_LIMIT   6'h18
`define DPS_A_OSEL    6'h1c
`define DPS_A_DIGF    6'h20
`define DPS_A_PRESET  6'h24
`define DPS_A_STAT    6'h28
`define DPS_A_MON     6'h2c
// mode register fields
`define DPS_F_DMODE   7:0
`define DPS_F_OPMODE  11:8
`define DPS_F_REMOTE  15:12
`define DPS_B_ENASGN  16
// reset values
`define DPS_R_MODE    32'h0000_0000
`define DPS_R_SETPT   16'h270f
`define DPS_R_BIAS    16'h0000
`define DPS_R_GAIN    16'h1388
`define DPS_R_PIDK    32'h0004_0010
`define DPS_R_RAMP    32'h1010_1010
`define DPS_R_LIMIT   32'h0032_1388
`define DPS_R_OSEL    32'h0000_0000
`define DPS_R_DIGF    32'h0096_0000
`define DPS_R_PRESET  32'h0000_0000
// codes
`define DPS_M_REV_FIX 8'h28
`define DPS_M_FWD_FIX 8'h29
`define DPS_M_REV_RAT 8'h2a
`define DPS_M_FWD_RAT 8'h2b
`define DPS_OP_PUEXT  4'h3
`define DPS_OP_SWOVR  4'h6
`define DPS_OF_POS    8'h2f
`define DPS_OF_NEG    8'h93
`define DPS_MON_SP    8'h34
`define DPS_MON_PV    8'h35
`define DPS_MON_DEV   8'h36
`define DPS_SP_UNSET  16'h270f
`define DPS_SP_MID    32'sd500
`define DPS_PCT_FULL  32'sd1000
`define DPS_DEV_OFS   32'sd1000
`define DPS_LOW_BRAKE 16'h0032
// timing: control period and clock period in ns
`define DPS_CTRL_PERIOD_NS 1000000
`define DPS_CLK_NS         25
`define DPS_CTRL_TICKS     (`DPS_CTRL_PERIOD_NS / `DPS_CLK_NS)
`endif

//--- dps_dancer_ctrl.v
/*
  dancer-roller speed regulator: a periodic pi correction from set point
  and roller position is added to a ramped main speed, with apb registers.
  assumes pins arrive asynchronously, apb runs on clk, frequencies are in
  0.01 hz units and percentages in 0.1 % units (1000 = 100 %).
*/
`timescale 1ns/10ps
`include "dps_defines.vh"
module dps_dancer_ctrl #(
  parameter CTRL_TICKS = `DPS_CTRL_TICKS // control period in clocks
) (
  // clock and reset
  input  wire        clk,
  input  wire        srst,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [5:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // pins from the machine
  input  wire        dancer_enable_input,
  input  wire        start_cmd,
  input  wire        ext_mode,
  input  wire        inching_select,
  input  wire [3:0]  multi_speed_selects,
  input  wire        current_input_select,
  input  wire [9:0]  position_input,
  input  wire [15:0] analog_main_input,
  // same-clock compensation from the remote-setting logic
  input  wire [15:0] remote_comp,
  // drive outputs
  output reg  [15:0] output_freq,
  output reg         dc_brake,
  output reg         loop_active_output,
  output reg         speed_reached_flag,
  output reg  [1:0]  out_term,
  output reg  [9:0]  analog_monitor_out
);
  // registers written by software
  reg  [31:0] mode_q;                   // selector, op mode, remote, assign
  reg  [15:0] setpt_q;                  // dancer set point
  reg  [15:0] bias_q;                   // bias frequency setting
  reg  [15:0] gain_q;                   // gain frequency setting
  reg  [31:0] pidk_q;                   // [15:0] kp/16, [31:16] ki/256
  reg  [31:0] ramp_q;                   // per-tick steps, four bytes
  reg  [31:0] limit_q;                  // [15:0] max freq, [31:16] brake
  reg  [31:0] osel_q;                   // terminal and monitor codes
  reg  [31:0] digf_q;                   // [15:0] digital, [31:16] usual brake
  reg  [31:0] preset_q;                 // [15:0] inching, [31:16] multi
  // control state
  reg  [31:0] tick_cnt_q;               // control period counter
  reg         act_q;                    // regulation active last tick
  reg  [15:0] main_q;                   // ramped main speed
  reg  signed [31:0] integ_q;           // integral term, 0.1 %
  reg  signed [31:0] dev_q;             // last deviation
  reg  [15:0] setf_q;                   // set frequency monitor
  reg  [15:0] disp_q;                   // display monitor value
  // two-stage synchroniser for every pin
  // the current-input select is synchronised but never read: the
  // position input may not become the main speed under regulation
  localparam SW = 35;
  reg  [SW-1:0] sync1_q;
  reg  [SW-1:0] sync2_q;
  // packed pin vector, msb first; the slices below follow this order
  wire [SW-1:0] pins = {dancer_enable_input, start_cmd, ext_mode,
                        inching_select, multi_speed_selects,
                        current_input_select, position_input,
                        analog_main_input};
  wire        en_s    = sync2_q[34];
  wire        start_s = sync2_q[33];
  wire        ext_s   = sync2_q[32];
  wire        inch_s  = sync2_q[31];
  wire [3:0]  multi_s = sync2_q[30:27];
  wire [9:0]  pos_s   = sync2_q[25:16];
  wire [15:0] ana_s   = sync2_q[15:0];

  // first stage feeds the second only
  // reset clears both stages so no stale pin level survives srst
  always @(posedge clk) begin
    if (srst) begin
      sync1_q <= {SW{1'b0}};
      sync2_q <= {SW{1'b0}};
    end else begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
    end
  end

  // field views
  wire [7:0] dmode  = mode_q[`DPS_F_DMODE];
  wire [3:0] opmode = mode_q[`DPS_F_OPMODE];
  wire       remote = |mode_q[`DPS_F_REMOTE];
  wire       ratio  = dmode == `DPS_M_REV_RAT || dmode == `DPS_M_FWD_RAT;
  wire       fwd    = dmode == `DPS_M_FWD_FIX || dmode == `DPS_M_FWD_RAT;
  wire       dmode_ok = dmode >= `DPS_M_REV_FIX && dmode <= `DPS_M_FWD_RAT;
  wire       en_ok  = ~mode_q[`DPS_B_ENASGN] | en_s;
  // selector 0, or enable off while the assign bit is set, gives plain operation
  wire       active = dmode_ok && en_ok && opmode != `DPS_OP_SWOVR;
  // counter restarts at reset, so ticks keep a fixed phase to srst
  wire       tick   = tick_cnt_q == CTRL_TICKS - 1;

  // main speed source; position input is never a candidate
  reg [15:0] src_f;
  always @* begin
    // inching wins, then multi-speed, then analog when external
    // op mode 3 skips the analog input and falls to the digital value
    if (inch_s)
      src_f = preset_q[15:0];
    else if (|multi_s)
      src_f = preset_q[31:16];
    else if (ext_s && opmode != `DPS_OP_PUEXT)
      src_f = ana_s;
    else
      src_f = digf_q[15:0];
  end

  // remote compensation is dropped while regulating with remote on
  wire [15:0] comp_f = (active && remote) ? 16'h0000 : remote_comp;
  // saturating sum: a wrap here would throw the motor to a low speed
  // instead of holding it at the top of the range
  wire [16:0] tgt_w  = {1'b0, src_f} + {1'b0, comp_f};
  wire [15:0] tgt_f  = tgt_w[16] ? 16'hffff : tgt_w[15:0];

  // one ramp step of cur toward tgt
  // a step size of zero freezes that ramp; users must not program it
  function [15:0] step;
    input [15:0] cur;
    input [15:0] tgt;
    input [7:0]  up;
    input [7:0]  dn;
    begin
      if (tgt > cur)
        step = (tgt - cur > {8'h00, up}) ? cur + {8'h00, up} : tgt;
      else
        step = (cur - tgt > {8'h00, dn}) ? cur - {8'h00, dn} : tgt;
    end
  endfunction

  // pi arithmetic, scaled in 0.1 %
  // span of the bias..gain line; a zero span sets the max percent to 100 %
  wire signed [31:0] span = $signed({16'h0000, gain_q}) - $signed({16'h0000, bias_q});
  wire signed [31:0] sp   = (setpt_q == `DPS_SP_UNSET) ? `DPS_SP_MID
                                                       : $signed({16'h0000, setpt_q});
  wire signed [31:0] pv   = $signed({22'h000000, pos_s});
  wire signed [31:0] dev  = fwd ? pv - sp : sp - pv;
  // max frequency as percent of the bias..gain line
  wire signed [31:0] maxf = $signed({16'h0000, limit_q[15:0]});
  wire signed [31:0] mpct = (span > 0) ? (maxf - $signed({16'h0000, bias_q}))
                                         * `DPS_PCT_FULL / span : `DPS_PCT_FULL;
  wire signed [31:0] ilim = (mpct < `DPS_PCT_FULL) ? mpct : `DPS_PCT_FULL;
  // ki in 1/256 and kp in 1/16; the shifts act after the 32-bit products
  wire signed [31:0] isum = integ_q + ((dev * $signed({16'h0000, pidk_q[31:16]})) >>> 8);
  // upper clamp only at ilim; lower side is not tied to minimum frequency
  wire signed [31:0] inxt = (isum > ilim) ? ilim :
                            (isum < -`DPS_PCT_FULL) ? -`DPS_PCT_FULL : isum;
  // proportional part plus the stored integral, clamped to +/- 100 %
  wire signed [31:0] mv   = ((dev * $signed({16'h0000, pidk_q[15:0]})) >>> 4) + integ_q;
  wire signed [31:0] mvc  = (mv > `DPS_PCT_FULL) ? `DPS_PCT_FULL :
                            (mv < -`DPS_PCT_FULL) ? -`DPS_PCT_FULL : mv;
  // controlled variable to frequency: 0 % bias, 100 % gain
  wire signed [31:0] cfix = $signed({16'h0000, bias_q}) + span * mvc / `DPS_PCT_FULL;
  // ratio addition scales the correction by main speed over gain point
  wire signed [31:0] crat = (gain_q != 16'h0000) ? cfix * $signed({16'h0000, main_q})
                            / $signed({16'h0000, gain_q}) : 32'sd0;
  wire signed [31:0] corr = ratio ? crat : cfix;
  wire signed [31:0] setw = $signed({16'h0000, main_q}) + corr;
  // set frequency stays between zero and the maximum frequency
  wire signed [31:0] setc = (setw < 0) ? 32'sd0 : (setw > maxf) ? maxf : setw;
  // automatic switchover frequency has no path while regulating

  // the control loop, updated once per period
  always @(posedge clk) begin
    if (srst) begin
      tick_cnt_q <= 32'h0000_0000;
      act_q      <= 1'b0;
      main_q     <= 16'h0000;
      integ_q    <= 32'sd0;
      dev_q      <= 32'sd0;
      setf_q     <= 16'h0000;
      output_freq <= 16'h0000;
      dc_brake   <= 1'b0;
    end else begin
      tick_cnt_q <= tick ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
      // between ticks everything but the tick counter holds, so updates land on ticks only
      if (tick) begin
        act_q <= active;
        dev_q <= dev;
        // regulation starting: running output becomes main, no bump
        if (active && !act_q) begin
          main_q  <= output_freq;
          integ_q <= 32'sd0;
        end else if (active) begin
          // second times pace the main speed only
          main_q  <= step(main_q, tgt_f, ramp_q[7:0], ramp_q[15:8]);
          integ_q <= inxt;
        end else begin
          // plain operation runs at the valid set frequency
          main_q  <= tgt_f;
          integ_q <= 32'sd0;
        end
        setf_q <= active ? setc[15:0] : tgt_f;
        // normal times pace the output, so the slower ramp governs
        if (start_s) begin
          output_freq <= step(output_freq, active ? setc[15:0] : tgt_f,
                              ramp_q[23:16], ramp_q[31:24]);
          dc_brake    <= 1'b0;
        end else begin
          output_freq <= step(output_freq, 16'h0000,
                              ramp_q[23:16], ramp_q[31:24]);
          // under regulation the lower of the limit brake frequency and the low threshold replaces the usual one
          if (active)
            dc_brake <= output_freq <= ((limit_q[31:16] < `DPS_LOW_BRAKE) ?
                        limit_q[31:16] : `DPS_LOW_BRAKE);
          else
            dc_brake <= output_freq <= digf_q[31:16];
        end
      end
    end
  end

  // status pins and monitors, all registered
  wire [7:0] dsel = osel_q[23:16];
  wire [7:0] asel = osel_q[31:24];
  reg  [9:0] ao_d;
  reg  [15:0] disp_d;
  // deviation shifted so that zero reads 1000; low half is displayed
  wire [31:0] dev_ofs = dev_q + `DPS_DEV_OFS;
  always @* begin
    // deviation has no analog form, so that select falls to zero
    case (asel)
      `DPS_MON_SP: ao_d = sp[9:0];
      `DPS_MON_PV: ao_d = pos_s;
      default:     ao_d = 10'h000;     // deviation not offered here
    endcase
    case (dsel)
      `DPS_MON_SP:  disp_d = sp[15:0];
      `DPS_MON_PV:  disp_d = {6'h00, pos_s};
      `DPS_MON_DEV: disp_d = dev_ofs[15:0];
      default:      disp_d = setf_q;
    endcase
  end

  always @(posedge clk) begin
    if (srst) begin
      loop_active_output <= 1'b0;
      speed_reached_flag <= 1'b0;
      analog_monitor_out <= 10'h000;
      disp_q             <= 16'h0000;
    end else begin
      // includes a stop while the loop still runs internally
      loop_active_output <= active;
      // regulation behaves as constant speed for the reached flag
      speed_reached_flag <= active | (start_s && output_freq == setf_q);
      // monitors registered so every output comes straight from a flop
      analog_monitor_out <= ao_d;
      disp_q             <= disp_d;
    end
  end

  // output terminals: one per function code byte
  // codes other than 47 and 147 leave the terminal low; the inverted
  // code reads high whenever regulation is off
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_term
      always @(posedge clk) begin
        if (srst)
          out_term[g] <= 1'b0;
        else if (osel_q[8*g+7:8*g] == `DPS_OF_POS)
          out_term[g] <= active;
        else if (osel_q[8*g+7:8*g] == `DPS_OF_NEG)
          out_term[g] <= ~active;
        else
          out_term[g] <= 1'b0;
      end
    end
  endgenerate

  // apb: read data prepared in setup, answered in the first access cycle
  // zero wait states: pready is the setup cycle delayed by one clock
  wire       setup = psel & ~penable;
  wire       wr    = psel & penable & pready & pwrite;
  reg [31:0] rd_d;
  // hit marks mapped, word-aligned offsets only
  reg        hit;
  always @* begin
    hit = 1'b1;
    case (paddr)
      `DPS_A_MODE:   rd_d = mode_q;
      `DPS_A_SETPT:  rd_d = {16'h0000, setpt_q};
      `DPS_A_BIAS:   rd_d = {16'h0000, bias_q};
      `DPS_A_GAIN:   rd_d = {16'h0000, gain_q};
      `DPS_A_PIDK:   rd_d = pidk_q;
      `DPS_A_RAMP:   rd_d = ramp_q;
      `DPS_A_LIMIT:  rd_d = limit_q;
      `DPS_A_OSEL:   rd_d = osel_q;
      `DPS_A_DIGF:   rd_d = digf_q;
      `DPS_A_PRESET: rd_d = preset_q;
      `DPS_A_STAT:   rd_d = {12'h000, dc_brake, speed_reached_flag,
                             loop_active_output, active, main_q};
      `DPS_A_MON:    rd_d = {setf_q, disp_q};
      default: begin
        rd_d = 32'h0000_0000;
        hit  = 1'b0;
      end
    endcase
  end

  // register writes and bus answer
  always @(posedge clk) begin
    if (srst) begin
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      prdata   <= 32'h0000_0000;
      mode_q   <= `DPS_R_MODE;
      setpt_q  <= `DPS_R_SETPT;
      bias_q   <= `DPS_R_BIAS;
      gain_q   <= `DPS_R_GAIN;
      pidk_q   <= `DPS_R_PIDK;
      ramp_q   <= `DPS_R_RAMP;
      limit_q  <= `DPS_R_LIMIT;
      osel_q   <= `DPS_R_OSEL;
      digf_q   <= `DPS_R_DIGF;
      preset_q <= `DPS_R_PRESET;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~hit;
      // read data drops to zero outside the access cycle
      prdata  <= (setup && !pwrite) ? rd_d : 32'h0000_0000;
      // writes land on the access edge, the one at which pready is seen;
      // mode keeps only bits 16:0, the rest read back as zero
      if (wr) begin
        case (paddr)
          `DPS_A_MODE:   mode_q   <= {15'h0000, pwdata[16:0]};
          `DPS_A_SETPT:  setpt_q  <= pwdata[15:0];
          `DPS_A_BIAS:   bias_q   <= pwdata[15:0];
          `DPS_A_GAIN:   gain_q   <= pwdata[15:0];
          `DPS_A_PIDK:   pidk_q   <= pwdata;
          `DPS_A_RAMP:   ramp_q   <= pwdata;
          `DPS_A_LIMIT:  limit_q  <= pwdata;
          `DPS_A_OSEL:   osel_q   <= pwdata;
          `DPS_A_DIGF:   digf_q   <= pwdata;
          `DPS_A_PRESET: preset_q <= pwdata;
          default: ;     // read-only and unmapped writes dropped
        endcase
      end
    end
  end
endmodule

//--- dps_dancer_ctrl_sva.sv
/* checker for the dancer regulator: apb timing, reset, tick and status.
   assumes it is bound to dps_dancer_ctrl and sees its ports only. */
`timescale 1ns/10ps
`include "dps_defines.vh"
module dps_dancer_ctrl_sva #(
  parameter CTRL_TICKS = 8 // control period in clocks
) (
  // clock and reset
  input logic        clk,
  input logic        srst,
  // apb
  input logic        psel,
  input logic        penable,
  input logic [5:0]  paddr,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  // drive outputs
  input logic [15:0] output_freq,
  input logic        dc_brake,
  input logic        loop_active_output,
  input logic        speed_reached_flag,
  input logic [1:0]  out_term
);
  reg [31:0] tick_cnt_q; // mirrors the control period counter
  // free-running period count, restarted by reset like the design's
  always @(posedge clk) begin
    if (srst) tick_cnt_q <= 32'h0;
    else if (tick_cnt_q == CTRL_TICKS - 1) tick_cnt_q <= 32'h0;
    else tick_cnt_q <= tick_cnt_q + 32'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_setup;
    psel && !penable;
  endsequence
  a_ready_after_setup: assert property (s_setup |=> pready && penable)
    else $error("pready missing in first access cycle");
  a_ready_one_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_err_unmapped: assert property (pready |->
    pslverr == (paddr > 6'h2c || paddr[1:0] != 2'b00))
    else $error("pslverr does not match address map");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside access");
  a_reset_clears: assert property ($fell(srst) |-> {output_freq, dc_brake,
    loop_active_output, speed_reached_flag, out_term} == 21'h0)
    else $error("outputs not cleared by reset");
  a_freq_at_tick: assert property (!$stable(output_freq) |->
    $past(tick_cnt_q) == CTRL_TICKS - 1)
    else $error("output frequency moved off the control tick");
  a_reached_active: assert property (loop_active_output |-> speed_reached_flag)
    else $error("speed reached dropped while regulating");
  a_brake_low: assert property ($rose(dc_brake) && loop_active_output |->
    output_freq <= `DPS_LOW_BRAKE)
    else $error("brake started above low threshold");
endmodule
bind dps_dancer_ctrl dps_dancer_ctrl_sva #(.CTRL_TICKS(CTRL_TICKS)) chk_i (
  .clk(clk), .srst(srst), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .output_freq(output_freq),
  .dc_brake(dc_brake), .loop_active_output(loop_active_output),
  .speed_reached_flag(speed_reached_flag), .out_term(out_term));

//--- dps_sensor_model.sv
/* roller position sensor: reports the commanded roller position.
   assumes the bench clock and reset. */
`timescale 1ns/10ps
module dps_sensor_model (
  // clock and reset
  input wire       clk,
  input wire       srst,
  // commanded roller position, 1000 = full travel
  input wire [9:0] pos_set,
  // position seen by the regulator
  output reg [9:0] position_input
);
  // one clock of settling; travel clamped since the roller cannot pass its stop
  always @(posedge clk) begin
    if (srst) position_input <= 10'h000;
    else position_input <= (pos_set > 10'd1000) ? 10'd1000 : pos_set;
  end
endmodule

//--- testbench.sv
/* bench for the dancer regulator: apb register and pin scenarios.
   assumes the design, its checker bind and the sensor model. */
`timescale 1ns/10ps
`include "dps_defines.vh"
module testbench;
  localparam TK = 8; // shortened control period
  localparam [319:0] RV = {`DPS_R_PRESET, `DPS_R_DIGF, `DPS_R_OSEL, `DPS_R_LIMIT,
    `DPS_R_RAMP, `DPS_R_PIDK, 16'h0, `DPS_R_GAIN, 16'h0, `DPS_R_BIAS, 16'h0,
    `DPS_R_SETPT, `DPS_R_MODE};
  reg         clk, srst;           // clock and reset
  reg         psel, penable, pwrite; // apb request
  reg  [5:0]  paddr;
  reg  [31:0] pwdata, r;           // write data, last read data
  reg         e;                   // last pslverr
  wire [31:0] prdata;
  wire        pready, pslverr;
  reg         en, start, ext, inch, cur; // machine pins
  reg  [3:0]  multi;
  reg  [9:0]  pos_set;
  reg  [15:0] analog, comp;
  wire [9:0]  pos, amon;
  wire [15:0] freq;
  wire        brake, active, reached;
  wire [1:0]  term;
  integer     mismatches, checks_done, cyc, i;
  dps_sensor_model dps_sensor_model_i (.clk(clk), .srst(srst), .pos_set(pos_set),
    .position_input(pos));
  dps_dancer_ctrl #(.CTRL_TICKS(TK)) dps_dancer_ctrl_i (.clk(clk), .srst(srst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .dancer_enable_input(en),
    .start_cmd(start), .ext_mode(ext), .inching_select(inch),
    .multi_speed_selects(multi), .current_input_select(cur), .position_input(pos),
    .analog_main_input(analog), .remote_comp(comp), .output_freq(freq),
    .dc_brake(brake), .loop_active_output(active), .speed_reached_flag(reached),
    .out_term(term), .analog_monitor_out(amon));
  // 40 mhz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // hang guard, run needs about 600 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      report_and_stop;
    end
  end
  task report_and_stop;
    begin
      $display("mismatches %0d checks %0d", mismatches, checks_done);
      if (mismatches == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task apb(input w, input [5:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
        @(posedge clk);
        n = n + 1;
      end while (pready !== 1'b1 && n < 50);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wr(input [5:0] a, input [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input [5:0] a, input [31:0] x);
    begin
      apb(1'b0, a, 32'h0);
      chk(r, x);
    end
  endtask
  // pin sync plus n control periods and the status clock
  task tk(input integer n);
    repeat (n * TK + 3) @(posedge clk);
  endtask
  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 6'h0;
    pwdata = 32'h0;
    {en, start, ext, inch, cur} = 5'h0;
    multi = 4'h0;
    pos_set = 10'd500;
    analog = 16'h0300;
    comp = 16'h0;
    mismatches = 0;
    checks_done = 0;
    cyc = 0;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    for (i = 0; i < 10; i = i + 1) rd(i * 4, RV[i*32 +: 32]);
    wr(6'h3c, 32'hffff_ffff);
    chk(e, 1);
    rd(6'h3c, 32'h0);
    chk(e, 1);
    // term a positive, term b inverted, deviation shown, set point on analog
    wr(`DPS_A_OSEL, 32'h3436_932f);
    for (i = 0; i < 4; i = i + 1) begin
      wr(`DPS_A_MODE, 32'h28 + i);
      tk(2);
      apb(1'b0, `DPS_A_STAT, 32'h0);
      chk(r[17:16], 2'b11);
      chk({reached, active, term}, 4'b1101);
    end
    apb(1'b0, `DPS_A_MON, 32'h0);
    chk(r[15:0], 16'd1000);
    chk(amon, 10'd500);
    pos_set <= 10'd300;
    wr(`DPS_A_OSEL, 32'h3535_932f);
    tk(2);
    rd(`DPS_A_MON, {16'h0000, 16'd300});
    chk(amon, 10'd300);
    wr(`DPS_A_OSEL, 32'h3636_932f);
    tk(2);
    chk(amon, 10'd0);
    wr(`DPS_A_MODE, 32'h0001_0028);
    tk(2);
    chk({active, term}, 3'b010);
    en <= 1'b1;
    tk(2);
    chk(active, 1);
    wr(`DPS_A_MODE, 32'h0001_0628);
    tk(2);
    chk(active, 0);
    // main speed sources with regulation off
    wr(`DPS_A_MODE, 32'h0);
    wr(`DPS_A_PRESET, 32'h0200_0100);
    ext <= 1'b1;
    cur <= 1'b1;
    for (i = 0; i < 3; i = i + 1) begin
      inch <= (i == 0);
      multi <= (i < 2) ? 4'h1 : 4'h0;
      tk(2);
      apb(1'b0, `DPS_A_STAT, 32'h0);
      chk(r[15:0], (i == 0) ? 16'h0100 : (i == 1) ? 16'h0200 : 16'h0300);
    end
    ext <= 1'b0;
    wr(`DPS_A_MODE, 32'h0300);
    wr(`DPS_A_DIGF, 32'h0096_0400);
    for (i = 0; i < 2; i = i + 1) begin
      multi <= (i == 0) ? 4'h1 : 4'h0;
      tk(2);
      apb(1'b0, `DPS_A_STAT, 32'h0);
      chk(r[15:0], (i == 0) ? 16'h0200 : 16'h0400);
    end
    // remote on under regulation: compensation must not reach main speed
    ext <= 1'b1;
    comp <= 16'h0055;
    pos_set <= 10'd500;
    wr(`DPS_A_RAMP, 32'h1010_10ff);
    wr(`DPS_A_MODE, 32'h1028);
    tk(7);
    apb(1'b0, `DPS_A_MON, 32'h0);
    chk(r[31:16], 16'h0300);
    // stop under regulation with a brake frequency below the low limit
    wr(`DPS_A_LIMIT, 32'h0010_1388);
    wr(`DPS_A_MODE, 32'h28);
    start <= 1'b1;
    tk(4);
    start <= 1'b0;
    tk(1);
    chk(reached, 1);
    i = 0;
    while (brake !== 1'b1 && i < 400) begin
      @(posedge clk);
      i = i + 1;
    end
    chk(brake, 1);
    chk(freq <= 16'h0010, 1);
    report_and_stop;
  end
endmodule
